// ### sim/jcc_scan_host.sv
`timescale 1ns/1ps
// ************************************************************
// Scan host model: drives the test clock only within frames and the TAP reset sequence
// ************************************************************
module jcc_scan_host (
	// Scan lines
	output logic tck,
	output logic trstN,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdoOe
);
	// Idle clock low, reset released after power-up
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trstN = 1'b0;
		#100 trstN = 1'b1;
	end
	// One 48 ns test clock; tdo taken just before the rise
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#24 o = tdo;
		tck = 1'b1;
		#24 tck = 1'b0;
	endtask : step
	// Five ones reach reset, then park in Run-Test/Idle
	task automatic reset_tap();
		logic o;
		repeat (5) step(1'b1, tdi, o);
		step(1'b0, tdi, o);
	endtask : reset_tap
	// Frame from idle, shifts n bits LSB first
	task automatic shift(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b1, tdi, o);
		if (ir) step(1'b1, tdi, o);
		step(1'b0, tdi, o);
		step(1'b0, tdi, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
		// Released data line shows no stale value
		tdi = ~tdi;
	endtask : shift
endmodule : jcc_scan_host

// ### sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
`define WAITC(c) for (wn = 0; !(c) && wn < 400; wn++) @(posedge clk); \
	if (wn >= 400) begin fail_count++; print_verdict(); end
module tb_top;
	localparam int NW = 2;
	logic clk, srst, psel, penable, pwrite, psDclk, globalClearN, globalOutputEnable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, o, w;
	logic pready, pslverr, err, tck, trstN, tms, tdi, tdo, tdoOe;
	logic esOut, esOe, ccOut, ccOe, chainEnableOutN, userIoOe, userClearN, reqN;
	logic [7:0] userPinIn;
	int fail_count, total_checks, wn, xsum;
	int words[$];
	// Pull-ups on both open-drain status lines
	wire esIn = esOe ? esOut : 1'b1;
	wire ccIn = ccOe ? ccOut : 1'b1;
	jcc_scan_host u_host (.tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdoOe(tdoOe));
	// Chain enable grounded; request high but for one test
	jcc_config_loader #(.CFG_WORDS(NW)) u_dut (.clk(clk), .srst(srst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdoOe(tdoOe), .configRequestN(reqN), .chainEnableInN(1'b0),
		.schemeSelect(jcc_pkg::SCHEME_PS), .psDclk(psDclk), .psData(1'b1),
		.configErrorStatusNIn(esIn), .configErrorStatusNOut(esOut),
		.configErrorStatusNOe(esOe), .configCompleteIn(ccIn), .configCompleteOut(ccOut),
		.configCompleteOe(ccOe), .chainEnableOutN(chainEnableOutN),
		.globalClearN(globalClearN), .globalOutputEnable(globalOutputEnable),
		.userPinIn(userPinIn), .userIoOe(userIoOe), .userClearN(userClearN));
	// 100 MHz system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Counts, then verdict, then stop
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	// APB transfer held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n >= 20) begin fail_count++; print_verdict(); end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Instruction load; capture pattern must come out first
	task automatic load_ir(input logic [3:0] code);
		u_host.shift(1'b1, 4, {28'h0, code}, o);
		`CHK("ir capture", 32'h1, o)
	endtask : load_ir
	initial begin
		{psel, penable, pwrite, psDclk, paddr, pwdata} = '0;
		{globalClearN, globalOutputEnable, userPinIn} = '0;
		reqN = 1'b1;
		fail_count = 0;
		total_checks = 0;
		srst = 1'b1;
		void'($urandom(32'hfed4));
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		u_host.reset_tap();
		// Register reset values and an unmapped place
		apb(1'b0, jcc_pkg::OFS_CTRL, 0);
		`CHK("ctrl", 32'h0, rd)
		apb(1'b0, jcc_pkg::OFS_EXPECT, 0);
		`CHK("expect", NW, rd)
		apb(1'b1, 12'h020, 32'hffff);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		$display("test registers done");
		// Bypass with user-side lines toggling meanwhile
		load_ir(jcc_pkg::INS_BYPASS);
		w = $urandom();
		@(posedge clk);
		{globalClearN, globalOutputEnable, userPinIn} <= $urandom();
		u_host.shift(1'b0, 32, w, o);
		`CHK("bypass", {w[30:0], 1'b0}, o)
		`CHK("scan float", 1'b0, tdoOe)
		`CHK("chain out", 1'b1, chainEnableOutN)
		`CHK("complete held", 1'b1, ccOe)
		$display("test bypass done");
		// Passive load running, then a scan load takes over
		@(posedge clk);
		globalOutputEnable <= 1'b1;
		apb(1'b1, jcc_pkg::OFS_CTRL, 32'h1);
		repeat (4) begin
			psDclk <= ~psDclk;
			repeat (6) @(posedge clk);
		end
		apb(1'b0, jcc_pkg::OFS_STAT, 0);
		`CHK("ps busy", 1'b1, rd[jcc_pkg::STAT_PS])
		load_ir(jcc_pkg::INS_PROGRAM);
		repeat (10) @(posedge clk);
		apb(1'b0, jcc_pkg::OFS_STAT, 0);
		`CHK("ps aborted", 2'b01, {rd[jcc_pkg::STAT_PS], rd[jcc_pkg::STAT_JTAG]})
		`CHK("user float", 1'b0, userIoOe)
		// Clear toggled mid-load must leave the load alone
		globalClearN <= ~globalClearN;
		xsum = 0;
		repeat (NW) begin
			words.push_back($urandom());
			xsum = xsum ^ words[$];
			u_host.shift(1'b0, 32, words[$], o);
		end
		load_ir(jcc_pkg::INS_STARTUP);
		`WAITC(chainEnableOutN === 1'b0)
		`CHK("complete released", 1'b0, ccOe)
		`CHK("no error", 1'b0, esOe)
		apb(1'b0, jcc_pkg::OFS_WCNT, 0);
		`CHK("word count", words.size(), rd)
		apb(1'b0, jcc_pkg::OFS_CHECK, 0);
		`CHK("word xor", xsum, rd)
		load_ir(jcc_pkg::INS_CHECK);
		u_host.shift(1'b0, 2, 32'h0, o);
		`CHK("scan status", 32'h1, o)
		// Pins may be sampled again once loading is over
		load_ir(jcc_pkg::INS_SAMPLE);
		u_host.shift(1'b0, 8, 32'h0, o);
		`CHK("sample", userPinIn, o[7:0])
		repeat (10) @(posedge clk);
		`CHK("user drive", 1'b1, userIoOe)
		`CHK("user clear", globalClearN, userClearN)
		$display("test load done");
		// Short load ends in error with completion held low
		load_ir(jcc_pkg::INS_PROGRAM);
		u_host.shift(1'b0, 32, $urandom(), o);
		load_ir(jcc_pkg::INS_STARTUP);
		`WAITC(esOe === 1'b1)
		`CHK("complete low", 1'b1, ccOe)
		apb(1'b0, jcc_pkg::OFS_STAT, 0);
		`CHK("status err", 1'b1, rd[jcc_pkg::STAT_ERR])
		`CHK("wires low", 2'b00, {rd[jcc_pkg::STAT_DONE_PIN], rd[jcc_pkg::STAT_ERR_PIN_N]})
		$display("test error done");
		// Request pulled low drops the engine back to idle
		reqN <= 1'b0;
		repeat (5) @(posedge clk);
		reqN <= 1'b1;
		`CHK("error released", 1'b0, esOe)
		apb(1'b0, jcc_pkg::OFS_STAT, 0);
		`CHK("request idle", 3'h0, rd[2:0])
		$display("test request done");
		print_verdict();
	end
endmodule : tb_top

// ### src/jcc_config_loader.sv
`timescale 1ns/1ps
// How it works
// [R1] Bypass routes scan input to output through one bit, internals untouched.
// [R2] Bypassed data appears on scan output one test clock later.
// [R3] Host loads bypass into every non-target device of the chain.
// [R4] Scan pins are never reused for user functions.
// [R5] Scan testing before and after loading only, never during loading.
// [R6] Global clear and output enable never touch scan or loading.
// [R7] Outside party holds chain-enable input low during scan loading.
// [R8] Outside party keeps configuration request high during scan loading.
// [R9] A loading error pulls the open-drain error line low before finishing.
// [R10] Successful loading releases the completion line so it rises.
// [R11] Finished loading drives chain-enable output low for the next device.
// [R12] Successful scan loading also drives chain-enable output low.
// [R13] Host grounds chain-enable inputs or loads devices in chain order.
// [R14] Host reads completion line over scan port: low fails, high succeeds.
// [R15] Host starts initialization of all chained devices together.
// [R16] User pins float for the whole scan loading.
// [R17] Scan loading start abandons any passive serial load in progress.
// [R18] Scan input taken on rising, output changed on falling, floats idle.
// [R19] Chain-enable output stays high from reset until successful loading.
module jcc_config_loader #(
	parameter int WORD_W = 32,
	parameter int CNT_W = 16,
	parameter int USER_W = 8,
	parameter int CFG_WORDS = 16
) (
	// System clock and reset
	input wire logic clk,
	input wire logic srst,
	// APB register port
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Scan port on the test clock
	input wire logic tck,
	input wire logic trstN,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdoOe,
	// Configuration pins
	input wire logic configRequestN,
	input wire logic chainEnableInN,
	input wire logic [1:0] schemeSelect,
	input wire logic psDclk,
	input wire logic psData,
	input wire logic configErrorStatusNIn,
	output logic configErrorStatusNOut,
	output logic configErrorStatusNOe,
	input wire logic configCompleteIn,
	output logic configCompleteOut,
	output logic configCompleteOe,
	output logic chainEnableOutN,
	// User side
	input wire logic globalClearN,
	input wire logic globalOutputEnable,
	input wire logic [USER_W-1:0] userPinIn,
	output logic userIoOe,
	output logic userClearN
);

	localparam int BC_W = $clog2(WORD_W);

	// Widths the register map and counters can carry
	if (WORD_W < 2 || WORD_W > 32 || CNT_W < 2 || CNT_W > 31 || CFG_WORDS < 1
		|| CFG_WORDS >= (1 << CNT_W)) begin : g_chk
		$error("jcc_config_loader: unsupported parameter values");
	end

	// Shift state decode shared by output enable and checks
	function automatic logic isShift(input jcc_pkg::jcc_tap_t st);
		isShift = (st == jcc_pkg::TAP_SH_DR) || (st == jcc_pkg::TAP_SH_IR);
	endfunction : isShift

	// Unknown codes fall back to bypass; sampling blocked while loading
	// [R5] No scan testing mid-load
	function automatic logic [jcc_pkg::IR_W-1:0] insSel(
		input logic [jcc_pkg::IR_W-1:0] ir, input logic busy);
		insSel = jcc_pkg::INS_BYPASS;
		if (ir == jcc_pkg::INS_PROGRAM || ir == jcc_pkg::INS_STARTUP || ir == jcc_pkg::INS_CHECK)
			insSel = ir;
		else if (ir == jcc_pkg::INS_SAMPLE && !busy)
			insSel = ir;
	endfunction : insSel

	// ************************************************************
	// Test clock domain
	// ************************************************************
	jcc_pkg::jcc_tap_t tap_ff, nxt_tap;
	logic [jcc_pkg::IR_W-1:0] irSr_ff, nxt_irSr, ir_ff, nxt_ir, ins;
	logic bypass_ff, nxt_bypass;
	logic [WORD_W-1:0] cfgSr_ff, nxt_cfgSr, word_ff, nxt_word;
	logic [BC_W-1:0] bitCnt_ff, nxt_bitCnt;
	logic [1:0] statSr_ff, nxt_statSr;
	logic [USER_W-1:0] smpSr_ff, nxt_smpSr;
	logic wordTgl_ff, nxt_wordTgl, startTgl_ff, nxt_startTgl, finTgl_ff, nxt_finTgl;
	logic [2:0] tStat1_ff, tStat2_ff;
	logic [USER_W-1:0] tPin1_ff, tPin2_ff;
	logic tdo_ff, tdoOe_ff, tdoBit;
	// Engine pin flops, declared here as the status sync below reads them
	logic chainN_ff, errOe_ff, doneOe_ff, ioOe_ff, clrN_ff, cfgBusy_ff, odLow_ff;

	// Engine status and user pins into the test clock domain
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			tStat1_ff <= '0;
			tStat2_ff <= '0;
			tPin1_ff <= '0;
			tPin2_ff <= '0;
		end else begin
			tStat1_ff <= {cfgBusy_ff, errOe_ff, ~doneOe_ff};
			tStat2_ff <= tStat1_ff;
			tPin1_ff <= userPinIn;
			tPin2_ff <= tPin1_ff;
		end
	end

	assign ins = insSel(ir_ff, tStat2_ff[2]);

	// Controller walk and data registers
	// [R4] Scan pins dedicated here
	always_comb begin
		nxt_tap = tap_ff;
		nxt_irSr = irSr_ff;
		nxt_ir = ir_ff;
		nxt_bypass = bypass_ff;
		nxt_cfgSr = cfgSr_ff;
		nxt_word = word_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_statSr = statSr_ff;
		nxt_smpSr = smpSr_ff;
		nxt_wordTgl = wordTgl_ff;
		nxt_startTgl = startTgl_ff;
		nxt_finTgl = finTgl_ff;
		unique case (tap_ff)
			jcc_pkg::TAP_TLR: nxt_tap = tms ? jcc_pkg::TAP_TLR : jcc_pkg::TAP_RTI;
			jcc_pkg::TAP_RTI: nxt_tap = tms ? jcc_pkg::TAP_SEL_DR : jcc_pkg::TAP_RTI;
			jcc_pkg::TAP_SEL_DR: nxt_tap = tms ? jcc_pkg::TAP_SEL_IR : jcc_pkg::TAP_CAP_DR;
			jcc_pkg::TAP_CAP_DR: nxt_tap = tms ? jcc_pkg::TAP_EX1_DR : jcc_pkg::TAP_SH_DR;
			jcc_pkg::TAP_SH_DR: nxt_tap = tms ? jcc_pkg::TAP_EX1_DR : jcc_pkg::TAP_SH_DR;
			jcc_pkg::TAP_EX1_DR: nxt_tap = tms ? jcc_pkg::TAP_UP_DR : jcc_pkg::TAP_PA_DR;
			jcc_pkg::TAP_PA_DR: nxt_tap = tms ? jcc_pkg::TAP_EX2_DR : jcc_pkg::TAP_PA_DR;
			jcc_pkg::TAP_EX2_DR: nxt_tap = tms ? jcc_pkg::TAP_UP_DR : jcc_pkg::TAP_SH_DR;
			jcc_pkg::TAP_UP_DR: nxt_tap = tms ? jcc_pkg::TAP_SEL_DR : jcc_pkg::TAP_RTI;
			jcc_pkg::TAP_SEL_IR: nxt_tap = tms ? jcc_pkg::TAP_TLR : jcc_pkg::TAP_CAP_IR;
			jcc_pkg::TAP_CAP_IR: nxt_tap = tms ? jcc_pkg::TAP_EX1_IR : jcc_pkg::TAP_SH_IR;
			jcc_pkg::TAP_SH_IR: nxt_tap = tms ? jcc_pkg::TAP_EX1_IR : jcc_pkg::TAP_SH_IR;
			jcc_pkg::TAP_EX1_IR: nxt_tap = tms ? jcc_pkg::TAP_UP_IR : jcc_pkg::TAP_PA_IR;
			jcc_pkg::TAP_PA_IR: nxt_tap = tms ? jcc_pkg::TAP_EX2_IR : jcc_pkg::TAP_PA_IR;
			jcc_pkg::TAP_EX2_IR: nxt_tap = tms ? jcc_pkg::TAP_UP_IR : jcc_pkg::TAP_SH_IR;
			jcc_pkg::TAP_UP_IR: nxt_tap = tms ? jcc_pkg::TAP_SEL_DR : jcc_pkg::TAP_RTI;
		endcase
		unique case (tap_ff)
			jcc_pkg::TAP_TLR: nxt_ir = jcc_pkg::INS_BYPASS;
			jcc_pkg::TAP_CAP_IR: nxt_irSr = jcc_pkg::IR_CAPTURE;
			jcc_pkg::TAP_SH_IR: nxt_irSr = {tdi, irSr_ff[jcc_pkg::IR_W-1:1]};
			// [R17] Scan start event
			jcc_pkg::TAP_UP_IR: begin
				nxt_ir = irSr_ff;
				if (irSr_ff == jcc_pkg::INS_PROGRAM)
					nxt_startTgl = ~startTgl_ff;
				if (irSr_ff == jcc_pkg::INS_STARTUP)
					nxt_finTgl = ~finTgl_ff;
			end
			// [R14] Completion captured for host
			jcc_pkg::TAP_CAP_DR: begin
				nxt_bypass = 1'b0;
				nxt_bitCnt = '0;
				nxt_statSr = {tStat2_ff[1], tStat2_ff[0]};
				nxt_smpSr = tPin2_ff;
			end
			// [R1] [R2] Single bit bypass path
			jcc_pkg::TAP_SH_DR: begin
				if (ins == jcc_pkg::INS_BYPASS || ins == jcc_pkg::INS_STARTUP)
					nxt_bypass = tdi;
				if (ins == jcc_pkg::INS_CHECK)
					nxt_statSr = {tdi, statSr_ff[1]};
				if (ins == jcc_pkg::INS_SAMPLE)
					nxt_smpSr = {tdi, smpSr_ff[USER_W-1:1]};
				if (ins == jcc_pkg::INS_PROGRAM) begin
					nxt_cfgSr = {tdi, cfgSr_ff[WORD_W-1:1]};
					nxt_bitCnt = bitCnt_ff + 1'b1;
					if (bitCnt_ff == BC_W'(WORD_W - 1)) begin
						// Restart per word, so widths off a power of two still pair
						nxt_bitCnt = '0;
						nxt_word = {tdi, cfgSr_ff[WORD_W-1:1]};
						nxt_wordTgl = ~wordTgl_ff;
					end
				end
			end
			default: ;
		endcase
	end

	// Registers of the test clock domain
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			tap_ff <= jcc_pkg::TAP_TLR;
			irSr_ff <= jcc_pkg::IR_CAPTURE;
			ir_ff <= jcc_pkg::INS_BYPASS;
			bypass_ff <= 1'b0;
			cfgSr_ff <= '0;
			word_ff <= '0;
			bitCnt_ff <= '0;
			statSr_ff <= '0;
			smpSr_ff <= '0;
			wordTgl_ff <= 1'b0;
			startTgl_ff <= 1'b0;
			finTgl_ff <= 1'b0;
		end else begin
			tap_ff <= nxt_tap;
			irSr_ff <= nxt_irSr;
			ir_ff <= nxt_ir;
			bypass_ff <= nxt_bypass;
			cfgSr_ff <= nxt_cfgSr;
			word_ff <= nxt_word;
			bitCnt_ff <= nxt_bitCnt;
			statSr_ff <= nxt_statSr;
			smpSr_ff <= nxt_smpSr;
			wordTgl_ff <= nxt_wordTgl;
			startTgl_ff <= nxt_startTgl;
			finTgl_ff <= nxt_finTgl;
		end
	end

	// Output bit of whichever register sits between the scan pins
	always_comb begin
		tdoBit = bypass_ff;
		if (tap_ff == jcc_pkg::TAP_SH_IR)
			tdoBit = irSr_ff[0];
		else if (ins == jcc_pkg::INS_PROGRAM)
			tdoBit = cfgSr_ff[0];
		else if (ins == jcc_pkg::INS_CHECK)
			tdoBit = statSr_ff[0];
		else if (ins == jcc_pkg::INS_SAMPLE)
			tdoBit = smpSr_ff[0];
	end

	// [R18] Falling edge output, floats outside shift
	always_ff @(negedge tck or negedge trstN) begin
		if (!trstN) begin
			tdo_ff <= 1'b0;
			tdoOe_ff <= 1'b0;
		end else begin
			tdo_ff <= tdoBit;
			tdoOe_ff <= isShift(tap_ff);
		end
	end

	assign tdo = tdo_ff;
	assign tdoOe = tdoOe_ff;

	// ************************************************************
	// System clock domain
	// ************************************************************
	// Pins and toggles: two flops, third stage only for edges
	localparam int SY_W = 13;
	logic [SY_W-1:0] sy1_ff, sy2_ff, sy3_ff;
	always_ff @(posedge clk) begin
		if (srst) begin
			sy1_ff <= '0;
			sy2_ff <= '0;
			sy3_ff <= '0;
		end else begin
			sy1_ff <= {configRequestN, chainEnableInN, psDclk, psData, globalClearN,
				globalOutputEnable, schemeSelect, configErrorStatusNIn, configCompleteIn,
				startTgl_ff, finTgl_ff, wordTgl_ff};
			sy2_ff <= sy1_ff;
			sy3_ff <= sy2_ff;
		end
	end

	logic reqLow, ceInN, psRise, psBit, gClrN, gOe, evStart, evFin, evWord;
	logic [1:0] scheme;
	assign reqLow = ~sy2_ff[12];
	assign ceInN = sy2_ff[11];
	assign psRise = sy2_ff[10] & ~sy3_ff[10];
	assign psBit = sy2_ff[9];
	assign gClrN = sy2_ff[8];
	assign gOe = sy2_ff[7];
	assign scheme = sy2_ff[6:5];
	assign evStart = sy2_ff[2] ^ sy3_ff[2];
	assign evFin = sy2_ff[1] ^ sy3_ff[1];
	// Word stays put for a whole word of test clocks, long after the toggle lands
	assign evWord = sy2_ff[0] ^ sy3_ff[0];

	// APB slave: ready in the first access cycle
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic psEn_ff, nxt_psEn;
	logic [CNT_W-1:0] expect_ff, nxt_expect;
	logic wrEn, reconf;
	jcc_pkg::jcc_cfg_t cfg_ff, nxt_cfg;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [WORD_W-1:0] psSr_ff, nxt_psSr, check_ff, nxt_check;
	logic [BC_W-1:0] psCnt_ff, nxt_psCnt;

	assign wrEn = psel & penable & pready_ff & pwrite;
	assign reconf = wrEn && paddr == jcc_pkg::OFS_CTRL && pwdata[jcc_pkg::CTRL_RECONF];

	always_comb begin
		nxt_pready = psel & ~penable;
		nxt_pslverr = 1'b0;
		nxt_prdata = '0;
		nxt_psEn = psEn_ff;
		nxt_expect = expect_ff;
		if (psel && !penable) begin
			unique case (paddr)
				jcc_pkg::OFS_CTRL: nxt_prdata[jcc_pkg::CTRL_PS_EN] = psEn_ff;
				jcc_pkg::OFS_STAT: begin
					nxt_prdata[jcc_pkg::STAT_DONE] = cfg_ff == jcc_pkg::CFG_DONE;
					nxt_prdata[jcc_pkg::STAT_ERR] = cfg_ff == jcc_pkg::CFG_ERROR;
					nxt_prdata[jcc_pkg::STAT_JTAG] = cfg_ff == jcc_pkg::CFG_JLOAD;
					nxt_prdata[jcc_pkg::STAT_PS] = cfg_ff == jcc_pkg::CFG_PLOAD;
					nxt_prdata[jcc_pkg::STAT_CHAIN_N] = chainN_ff;
					nxt_prdata[jcc_pkg::STAT_ERR_PIN_N] = sy2_ff[4];
					nxt_prdata[jcc_pkg::STAT_DONE_PIN] = sy2_ff[3];
				end
				jcc_pkg::OFS_WCNT: nxt_prdata = {{(32-CNT_W){1'b0}}, cnt_ff};
				jcc_pkg::OFS_EXPECT: nxt_prdata = {{(32-CNT_W){1'b0}}, expect_ff};
				jcc_pkg::OFS_CHECK: nxt_prdata = 32'(check_ff);
				default: nxt_pslverr = 1'b1;
			endcase
		end
		if (wrEn && paddr == jcc_pkg::OFS_CTRL)
			nxt_psEn = pwdata[jcc_pkg::CTRL_PS_EN];
		if (wrEn && paddr == jcc_pkg::OFS_EXPECT)
			nxt_expect = pwdata[CNT_W-1:0];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_ff <= '0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			psEn_ff <= jcc_pkg::CTRL_PS_EN_RST;
			expect_ff <= CNT_W'(CFG_WORDS);
		end else begin
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			psEn_ff <= nxt_psEn;
			expect_ff <= nxt_expect;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// Loading engine; request low or soft reconfigure wins over all
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_cnt = cnt_ff;
		nxt_psSr = psSr_ff;
		nxt_psCnt = psCnt_ff;
		nxt_check = check_ff;
		if (reqLow || reconf) begin
			nxt_cfg = jcc_pkg::CFG_IDLE;
			nxt_cnt = '0;
			nxt_check = '0;
		// [R17] Scan start abandons passive load
		end else if (evStart) begin
			nxt_cfg = jcc_pkg::CFG_JLOAD;
			nxt_cnt = '0;
			nxt_psCnt = '0;
			nxt_check = '0;
		end else begin
			unique case (cfg_ff)
				jcc_pkg::CFG_IDLE: begin
					if (psEn_ff && scheme == jcc_pkg::SCHEME_PS && !ceInN && psRise) begin
						nxt_cfg = jcc_pkg::CFG_PLOAD;
						nxt_psSr = {psBit, psSr_ff[WORD_W-1:1]};
						nxt_psCnt = BC_W'(1);
					end
				end
				// [R9] Overrun or short load flags error
				jcc_pkg::CFG_JLOAD: begin
					if (evFin)
						nxt_cfg = (cnt_ff == expect_ff) ? jcc_pkg::CFG_DONE : jcc_pkg::CFG_ERROR;
					else if (evWord) begin
						nxt_check = check_ff ^ word_ff;
						nxt_cnt = cnt_ff + 1'b1;
						if (cnt_ff == expect_ff)
							nxt_cfg = jcc_pkg::CFG_ERROR;
					end
				end
				jcc_pkg::CFG_PLOAD: begin
					if (!psEn_ff || ceInN)
						nxt_cfg = jcc_pkg::CFG_IDLE;
					else if (psRise) begin
						nxt_psSr = {psBit, psSr_ff[WORD_W-1:1]};
						nxt_psCnt = psCnt_ff + 1'b1;
						if (psCnt_ff == BC_W'(WORD_W - 1)) begin
							nxt_psCnt = '0;
							nxt_check = check_ff ^ {psBit, psSr_ff[WORD_W-1:1]};
							nxt_cnt = cnt_ff + 1'b1;
							if (cnt_ff + 1'b1 == expect_ff)
								nxt_cfg = jcc_pkg::CFG_DONE;
						end
					end
				end
				jcc_pkg::CFG_DONE, jcc_pkg::CFG_ERROR: ;
				default: nxt_cfg = jcc_pkg::CFG_IDLE;
			endcase
		end
	end

	// Pins follow the next state so they move with it.
	// [R6] Clear and output enable touch only the user side
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_ff <= jcc_pkg::CFG_IDLE;
			cnt_ff <= '0;
			psSr_ff <= '0;
			psCnt_ff <= '0;
			check_ff <= '0;
			chainN_ff <= 1'b1;
			errOe_ff <= 1'b0;
			doneOe_ff <= 1'b1;
			ioOe_ff <= 1'b0;
			clrN_ff <= 1'b0;
			cfgBusy_ff <= 1'b0;
			odLow_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			cnt_ff <= nxt_cnt;
			psSr_ff <= nxt_psSr;
			psCnt_ff <= nxt_psCnt;
			check_ff <= nxt_check;
			// [R19] [R11] [R12] Chain hand-over
			chainN_ff <= nxt_cfg != jcc_pkg::CFG_DONE;
			// [R9] Error line pulled low
			errOe_ff <= nxt_cfg == jcc_pkg::CFG_ERROR;
			// [R10] Completion released
			doneOe_ff <= nxt_cfg != jcc_pkg::CFG_DONE;
			// [R16] User pins float while loading
			ioOe_ff <= nxt_cfg == jcc_pkg::CFG_DONE && gOe;
			clrN_ff <= gClrN;
			cfgBusy_ff <= nxt_cfg == jcc_pkg::CFG_JLOAD || nxt_cfg == jcc_pkg::CFG_PLOAD;
			odLow_ff <= 1'b0;
		end
	end

	assign chainEnableOutN = chainN_ff;
	assign configErrorStatusNOe = errOe_ff;
	assign configErrorStatusNOut = odLow_ff;
	assign configCompleteOe = doneOe_ff;
	assign configCompleteOut = odLow_ff;
	assign userIoOe = ioOe_ff;
	assign userClearN = clrN_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	bypass_delay_a: assert property (@(posedge tck) disable iff (!trstN) // [R2]
		(tap_ff == jcc_pkg::TAP_SH_DR && ins == jcc_pkg::INS_BYPASS) |=> bypass_ff == $past(tdi))
		else $error("bypass bit did not follow scan input");
	tdo_float_a: assert property (@(posedge tck) disable iff (!trstN) // [R18]
		tdoOe_ff == isShift(tap_ff))
		else $error("scan output enable outside shift");
	chain_held_a: assert property (@(posedge clk) disable iff (srst) // [R19]
		(cfg_ff != jcc_pkg::CFG_DONE) |-> chainN_ff)
		else $error("chain enable low before success");
	chain_low_a: assert property (@(posedge clk) disable iff (srst) // [R11]
		(cfg_ff == jcc_pkg::CFG_DONE) |-> !chainN_ff && !doneOe_ff)
		else $error("chain enable or completion wrong after success");
	err_drive_a: assert property (@(posedge clk) disable iff (srst) // [R9]
		(cfg_ff == jcc_pkg::CFG_JLOAD && evFin && cnt_ff != expect_ff && !reqLow && !reconf
		&& !evStart) |=> errOe_ff && chainN_ff)
		else $error("short load did not raise error line");
	done_release_a: assert property (@(posedge clk) disable iff (srst) // [R10]
		(cfg_ff == jcc_pkg::CFG_JLOAD && evFin && cnt_ff == expect_ff && !reqLow && !reconf
		&& !evStart) |=> !doneOe_ff ##1 !doneOe_ff)
		else $error("completion line not released");
	io_float_a: assert property (@(posedge clk) disable iff (srst) // [R16]
		(cfg_ff == jcc_pkg::CFG_JLOAD) |-> !ioOe_ff)
		else $error("user pins driven during scan load");
	ps_abort_a: assert property (@(posedge clk) disable iff (srst) // [R17]
		(cfg_ff == jcc_pkg::CFG_PLOAD && evStart && !reqLow && !reconf)
		|=> cfg_ff == jcc_pkg::CFG_JLOAD && cnt_ff == '0)
		else $error("passive load not abandoned");
	clear_ignored_a: assert property (@(posedge clk) disable iff (srst) // [R6]
		(cfg_ff == jcc_pkg::CFG_JLOAD && $changed(gClrN) && !reqLow && !reconf && !evFin
		&& !evWord && !evStart) |=> cfg_ff == jcc_pkg::CFG_JLOAD)
		else $error("global clear disturbed loading");
	apb_ready_a: assert property (@(posedge clk) disable iff (srst)
		(psel && !penable) |=> pready_ff ##1 !pready_ff)
		else $error("ready not exactly one access cycle");

	done_seen_c: cover property (@(posedge clk) disable iff (srst)
		cfg_ff == jcc_pkg::CFG_JLOAD ##[1:1000] cfg_ff == jcc_pkg::CFG_DONE);
	err_seen_c: cover property (@(posedge clk) disable iff (srst)
		cfg_ff == jcc_pkg::CFG_ERROR);
	abort_seen_c: cover property (@(posedge clk) disable iff (srst)
		cfg_ff == jcc_pkg::CFG_PLOAD ##1 cfg_ff == jcc_pkg::CFG_JLOAD);
	bypass_seen_c: cover property (@(posedge tck) disable iff (!trstN)
		tap_ff == jcc_pkg::TAP_SH_DR && ins == jcc_pkg::INS_BYPASS);

endmodule : jcc_config_loader

// ### src/jcc_pkg.sv
package jcc_pkg;

	// ************************************************************
	// Scan controller states and instructions
	// ************************************************************
	localparam int IR_W = 4;

	typedef enum logic [3:0] {
		TAP_EX2_DR = 4'h0,
		TAP_EX1_DR = 4'h1,
		TAP_SH_DR = 4'h2,
		TAP_PA_DR = 4'h3,
		TAP_SEL_IR = 4'h4,
		TAP_UP_DR = 4'h5,
		TAP_CAP_DR = 4'h6,
		TAP_SEL_DR = 4'h7,
		TAP_EX2_IR = 4'h8,
		TAP_EX1_IR = 4'h9,
		TAP_SH_IR = 4'ha,
		TAP_PA_IR = 4'hb,
		TAP_RTI = 4'hc,
		TAP_UP_IR = 4'hd,
		TAP_CAP_IR = 4'he,
		TAP_TLR = 4'hf
	} jcc_tap_t;

	localparam logic [IR_W-1:0] INS_PROGRAM = 4'h2;
	localparam logic [IR_W-1:0] INS_STARTUP = 4'h3;
	localparam logic [IR_W-1:0] INS_CHECK = 4'h4;
	localparam logic [IR_W-1:0] INS_SAMPLE = 4'h5;
	localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

	// ************************************************************
	// Configuration engine states
	// ************************************************************
	typedef enum logic [2:0] {
		CFG_IDLE = 3'h0,
		CFG_JLOAD = 3'h1,
		CFG_PLOAD = 3'h2,
		CFG_DONE = 3'h3,
		CFG_ERROR = 3'h4
	} jcc_cfg_t;

	localparam logic [1:0] SCHEME_PS = 2'h0;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_WCNT = 12'h008;
	localparam logic [11:0] OFS_EXPECT = 12'h00c;
	localparam logic [11:0] OFS_CHECK = 12'h010;

	localparam int CTRL_PS_EN = 0;
	localparam int CTRL_RECONF = 1;
	localparam logic CTRL_PS_EN_RST = 1'b0;

	localparam int STAT_DONE = 0;
	localparam int STAT_ERR = 1;
	localparam int STAT_JTAG = 2;
	localparam int STAT_PS = 3;
	localparam int STAT_CHAIN_N = 4;
	localparam int STAT_ERR_PIN_N = 5;
	localparam int STAT_DONE_PIN = 6;

endpackage : jcc_pkg
